//--- design/sacc_pkg.sv
// ****************************************************************
// Shared constants for the converter control block
// ****************************************************************
package sacc_pkg;

	// Clock rate and documented times
	localparam int CLK_PERIOD_NS = 8;
	localparam int INT_ACQ_NS    = 1000;
	localparam int INT_CONV_NS   = 3600;
	localparam int CONV_CYCLES   = 13;
	localparam int RES_BITS      = 10;

	// Derived cycle counts: least time rounds up, clock period rounds down
	localparam int INT_ACQ_CYC  = (INT_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INT_TICK_CYC = INT_CONV_NS / (CONV_CYCLES * CLK_PERIOD_NS);

	localparam logic [6:0] ACQ_CNT_LAST  = 7'(INT_ACQ_CYC - 1);
	localparam logic [5:0] TICK_CNT_LAST = 6'(INT_TICK_CYC - 1);
	localparam logic [3:0] CONV_LAST     = 4'(CONV_CYCLES - 1);
	localparam logic [3:0] SAR_FIRST     = 4'h1;
	localparam logic [3:0] SAR_LAST      = 4'(RES_BITS);
	localparam logic [2:0] ACQ_EDGE_LAST = 3'h3;

	// Control byte field positions
	localparam int CTL_PWR_HI = 7;
	localparam int CTL_PWR_LO = 6;
	localparam int CTL_ACQ    = 5;
	localparam int CTL_SGL    = 4;
	localparam int CTL_UNI    = 3;
	localparam int CTL_CH_MSB = 2;

	// Reset values
	localparam logic [7:0] CTL_RST      = 8'hc0;
	localparam logic       CLK_MODE_RST = 1'h1;
	localparam logic       INT_N_RST    = 1'h1;

	// Sequencer states
	typedef enum logic [1:0] {
		SACC_IDLE    = 2'b00,
		SACC_ACQ_INT = 2'b01,
		SACC_ACQ_EXT = 2'b10,
		SACC_CONV    = 2'b11
	} sacc_state_t;

	// Output byte: low byte, or top two bits with zero or sign fill
	function automatic logic [7:0] fmt_byte(input logic [9:0] res, input logic hi,
		input logic uni);
		logic [5:0] fill;
		fill = uni ? 6'h00 : {6{res[9]}};
		return hi ? {fill, res[9:8]} : res[7:0];
	endfunction

endpackage

//--- design/sacc_conv_if.sv
`timescale 1ns/1ps
// ****************************************************************
// Link between sequencer and approximation register
// ****************************************************************
interface sacc_conv_if;
	logic       tick;
	logic       start;
	logic       abort;
	logic       comp_hi;
	logic       busy;
	logic       done;
	logic [9:0] code;
	logic [9:0] result;

	modport ctrl (output tick, output start, output abort, output comp_hi,
		input busy, input done, input code, input result);
	modport sar (input tick, input start, input abort, input comp_hi,
		output busy, output done, output code, output result);
endinterface

//--- design/sacc_clkgen.sv
`timescale 1ns/1ps
// ****************************************************************
// Conversion clock: pin falling edges or internal divider
// ****************************************************************
module sacc_clkgen (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic conv_clk_pin,
	input  wire logic cs_n_s,
	input  wire logic ext_mode,
	input  wire logic div_clr,
	output logic      tick
);
	logic       pin_m_q;
	logic       pin_s_q;
	logic       pin_p_q;
	logic [5:0] div_q;
	logic       ext_fall;
	logic       int_tick;

	// Pin passes two flops before edge detection; divider restarts with
	// each run so the first internal period is a full one, not a fragment
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_m_q <= 1'h0;
			pin_s_q <= 1'h0;
			pin_p_q <= 1'h0;
			div_q   <= 6'h00;
		end else begin
			pin_m_q <= conv_clk_pin;
			pin_s_q <= pin_m_q;
			pin_p_q <= pin_s_q;
			div_q   <= (div_clr || div_q == sacc_pkg::TICK_CNT_LAST) ? 6'h00 : div_q + 6'h01; // R06
		end
	end

	// Deselected part ignores the clock pin
	assign ext_fall = pin_p_q & ~pin_s_q & ~cs_n_s; // R22
	assign int_tick = (div_q == sacc_pkg::TICK_CNT_LAST);
	assign tick     = ext_mode ? ext_fall : int_tick;

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	AST_PIN_GATED: assert property (ext_mode && cs_n_s |-> !tick) // R22
		else $error("clock pin edge used while deselected");
endmodule // sacc_clkgen

//--- design/sacc_sar.sv
`timescale 1ns/1ps
// ****************************************************************
// Successive approximation register, thirteen ticks per run
// ****************************************************************
module sacc_sar (
	input wire logic clock,
	input wire logic sys_rst,
	sacc_conv_if.sar cv
);
	logic [3:0] cnt_q;
	logic [9:0] code_q;
	logic       busy_q;
	logic       done_q;
	logic [3:0] bit_idx;
	logic       deciding;

	// Tick 0 switches the hold node, ticks 1..10 decide bits, rest settle
	assign bit_idx   = sacc_pkg::SAR_LAST - cnt_q;
	assign deciding  = busy_q & (cnt_q >= sacc_pkg::SAR_FIRST) & (cnt_q <= sacc_pkg::SAR_LAST);
	assign cv.code   = code_q | (deciding ? (10'h001 << bit_idx) : 10'h000);
	assign cv.busy   = busy_q;
	assign cv.done   = done_q;
	assign cv.result = code_q;

	// Abort beats start so a rewrite always drops the run
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt_q  <= 4'h0;
			code_q <= 10'h000;
			busy_q <= 1'h0;
			done_q <= 1'h0;
		end else begin
			done_q <= 1'h0;
			if (cv.abort) begin
				busy_q <= 1'h0; // R07
			end else if (cv.start) begin
				busy_q <= 1'h1;
				cnt_q  <= 4'h0;
				code_q <= 10'h000;
			end else if (busy_q && cv.tick) begin
				if (deciding) begin
					code_q[bit_idx] <= cv.comp_hi;
				end
				if (cnt_q == sacc_pkg::CONV_LAST) begin
					busy_q <= 1'h0; // R06
					done_q <= 1'h1;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	AST_THIRTEEN_TICKS: assert property ( // R06
		busy_q && cv.tick && !cv.abort && cnt_q == sacc_pkg::CONV_LAST |=> done_q && !busy_q)
		else $error("conversion did not end on the thirteenth tick");
endmodule // sacc_sar

//--- design/sacc_ctrl.sv
`timescale 1ns/1ps
// Function
// [R01] Control byte write starts a conversion
// [R02] Tracking begins on write strobe rising edge
// [R03] External acquisition holds on next write edge
// [R04] Internal acquisition holds on fourth falling edge
// [R05] Internal acquisition, internal clock: hold after 1us
// [R06] Conversion lasts thirteen conversion clock cycles
// [R07] Write during conversion aborts, restarts acquisition
// [R08] Acquisition bit clear: timed acquisition then conversion
// [R09] External acquisition: set-bit write, then clear-bit write
// [R10] Host keeps channel address on both writes
// [R11] Second write may change only power bits
// [R12] Interrupt goes low when result ready
// [R13] Interrupt returns high on read or write
// [R14] Power bits decode power and clock mode
// [R15] Bit 5 selects acquisition timing mode
// [R16] Bit 4 selects single-ended or channel pair
// [R17] Bit 3 selects unipolar or bipolar range
// [R18] Bits 2..0 address channel or pair
// [R19] Single-ended: channel positive, common pin negative
// [R20] High byte select picks result byte layout
// [R21] External clock mode after reset
// [R22] Deselected part ignores strobes, bus floats
// [R23] Power-down codes keep last clock mode
// [R24] Result held until next conversion completes
module sacc_ctrl (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       cs_n,
	input  wire logic       wr_n,
	input  wire logic       rd_n,
	input  wire logic       high_byte_sel,
	input  wire logic       conv_clk_pin,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	output logic            int_n,
	input  wire logic       comp_hi,
	output logic            hold_cap,
	output logic      [2:0] pos_chan,
	output logic      [2:0] neg_chan,
	output logic            neg_is_com,
	output logic            polarity_sel,
	output logic      [9:0] dac_code,
	output logic      [1:0] pwr_mode,
	output logic            ext_clk_mode,
	output logic            conv_busy
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	sacc_conv_if cv ();

	logic                  cs_m_q;
	logic                  cs_s_q;
	logic                  wr_m_q;
	logic                  wr_s_q;
	logic                  wr_p_q;
	logic                  rd_m_q;
	logic                  rd_s_q;
	logic                  rd_p_q;
	logic                  hbs_m_q;
	logic                  hbs_s_q;
	logic [7:0]            dat_m_q;
	logic [7:0]            dat_s_q;

	logic [7:0]            cfg_q;
	logic                  ext_clk_q;
	sacc_pkg::sacc_state_t state_q;
	sacc_pkg::sacc_state_t state_d;
	logic [2:0]            edge_cnt_q;
	logic [6:0]            acq_cnt_q;
	logic                  track_q;
	logic [9:0]            result_q;
	logic                  int_n_q;
	logic [7:0]            data_out_q;

	logic                  wr_event;
	logic                  rd_event;
	logic                  byte_acq;
	logic                  second_write;
	logic                  acq_ext_done;
	logic                  acq_int_done;
	logic                  acq_done;
	logic                  enter_conv;
	logic                  tick;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************

	// Every strobe and the bus pass two flops before use
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cs_m_q  <= 1'h1;
			cs_s_q  <= 1'h1;
			wr_m_q  <= 1'h1;
			wr_s_q  <= 1'h1;
			wr_p_q  <= 1'h1;
			rd_m_q  <= 1'h1;
			rd_s_q  <= 1'h1;
			rd_p_q  <= 1'h1;
			hbs_m_q <= 1'h0;
			hbs_s_q <= 1'h0;
			dat_m_q <= 8'h00;
			dat_s_q <= 8'h00;
		end else begin
			cs_m_q  <= cs_n;
			cs_s_q  <= cs_m_q;
			wr_m_q  <= wr_n;
			wr_s_q  <= wr_m_q;
			wr_p_q  <= wr_s_q;
			rd_m_q  <= rd_n;
			rd_s_q  <= rd_m_q;
			rd_p_q  <= rd_s_q;
			hbs_m_q <= high_byte_sel;
			hbs_s_q <= hbs_m_q;
			dat_m_q <= data_in;
			dat_s_q <= dat_m_q;
		end
	end

	// ****************************************************************
	// Strobe decode
	// ****************************************************************

	// Host must hold the byte stable across the write rising edge,
	// since the bus copy is sampled on the same delayed edge
	assign wr_event     = wr_s_q & ~wr_p_q & ~cs_s_q; // R01 R22
	assign rd_event     = ~rd_s_q & rd_p_q & ~cs_s_q; // R22
	assign byte_acq     = dat_s_q[sacc_pkg::CTL_ACQ]; // R15
	assign second_write = wr_event & ~byte_acq & (state_q == sacc_pkg::SACC_ACQ_EXT); // R09

	// ****************************************************************
	// Acquisition timing
	// ****************************************************************

	// Pin clock: fourth falling edge; internal clock: fixed 1us timer
	assign acq_ext_done = tick & (edge_cnt_q == sacc_pkg::ACQ_EDGE_LAST); // R04
	assign acq_int_done = (acq_cnt_q == sacc_pkg::ACQ_CNT_LAST); // R05
	assign acq_done     = (state_q == sacc_pkg::SACC_ACQ_INT) & ~wr_event
		& (ext_clk_q ? acq_ext_done : acq_int_done); // R08
	assign enter_conv   = second_write | acq_done; // R03

	// Counters restart on every write so a rewrite restarts the interval
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			edge_cnt_q <= 3'h0;
			acq_cnt_q  <= 7'h00;
		end else if (wr_event) begin
			edge_cnt_q <= 3'h0;
			acq_cnt_q  <= 7'h00;
		end else if (state_q == sacc_pkg::SACC_ACQ_INT) begin
			edge_cnt_q <= tick ? edge_cnt_q + 3'h1 : edge_cnt_q; // R04
			acq_cnt_q  <= acq_cnt_q + 7'h01; // R05
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************

	// A write always wins: it aborts any run and opens a new interval; a second write starts the run
	always_comb begin
		state_d = state_q;
		if (wr_event) begin
			if (second_write) begin
				state_d = sacc_pkg::SACC_CONV; // R09
			end else if (byte_acq) begin
				state_d = sacc_pkg::SACC_ACQ_EXT; // R07
			end else begin
				state_d = sacc_pkg::SACC_ACQ_INT; // R07 R08
			end
		end else begin
			unique case (state_q)
				sacc_pkg::SACC_IDLE: begin
					state_d = sacc_pkg::SACC_IDLE;
				end
				sacc_pkg::SACC_ACQ_INT: begin
					if (acq_done) begin
						state_d = sacc_pkg::SACC_CONV; // R08
					end
				end
				sacc_pkg::SACC_ACQ_EXT: begin
					state_d = sacc_pkg::SACC_ACQ_EXT;
				end
				sacc_pkg::SACC_CONV: begin
					if (cv.done) begin
						state_d = sacc_pkg::SACC_IDLE;
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q <= sacc_pkg::SACC_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Track switch closes on the write, opens when sampling ends
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			track_q <= 1'h0;
		end else if (enter_conv) begin
			track_q <= 1'h0; // R03 R04
		end else if (wr_event) begin
			track_q <= 1'h1; // R02
		end
	end

	// ****************************************************************
	// Configuration
	// ****************************************************************

	// Second write of a pair updates the power bits and clears bit 5; the mux
	// stays where the first write put it so the sample is not upset
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfg_q <= sacc_pkg::CTL_RST;
		end else if (second_write) begin
			cfg_q[sacc_pkg::CTL_PWR_HI] <= dat_s_q[sacc_pkg::CTL_PWR_HI]; // R11
			cfg_q[sacc_pkg::CTL_PWR_LO] <= dat_s_q[sacc_pkg::CTL_PWR_LO]; // R11
			cfg_q[sacc_pkg::CTL_ACQ]    <= 1'h0;
		end else if (wr_event) begin
			cfg_q <= dat_s_q; // R01
		end
	end

	// Clock mode only moves on a normal-operation code
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ext_clk_q <= sacc_pkg::CLK_MODE_RST; // R21
		end else if (wr_event && dat_s_q[sacc_pkg::CTL_PWR_HI]) begin
			ext_clk_q <= dat_s_q[sacc_pkg::CTL_PWR_LO]; // R14 R23
		end
	end

	// ****************************************************************
	// Approximation register and conversion clock
	// ****************************************************************
	sacc_clkgen u_clkgen (
		.clock        (clock),
		.sys_rst      (sys_rst),
		.conv_clk_pin (conv_clk_pin),
		.cs_n_s       (cs_s_q),
		.ext_mode     (ext_clk_q),
		.div_clr      (enter_conv),
		.tick         (tick)
	);

	sacc_sar u_sar (
		.clock   (clock),
		.sys_rst (sys_rst),
		.cv      (cv.sar)
	);

	// Run starts as sampling ends; a write in a run kills it
	assign cv.tick    = tick; // R06
	assign cv.start   = enter_conv;
	assign cv.abort   = wr_event & (state_q == sacc_pkg::SACC_CONV); // R07
	assign cv.comp_hi = comp_hi;

	// ****************************************************************
	// Result and interrupt
	// ****************************************************************

	// Result only changes on completion; completion beats a clearing read
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			result_q <= 10'h000;
			int_n_q  <= sacc_pkg::INT_N_RST;
		end else begin
			if (cv.done) begin
				result_q <= cv.result; // R24
				int_n_q  <= 1'h0; // R12
			end else if (rd_event || wr_event) begin
				int_n_q  <= 1'h1; // R13
			end
		end
	end

	// Output byte rebuilt every cycle, so a byte-select change shows
	// after the select's two sync flops plus this one
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			data_out_q <= 8'h00;
		end else begin
			data_out_q <= sacc_pkg::fmt_byte(result_q, hbs_s_q,
				cfg_q[sacc_pkg::CTL_UNI]); // R20
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// Pair mode: partner channel is the address with bit 0 flipped
	assign neg_is_com   = cfg_q[sacc_pkg::CTL_SGL]; // R16 R19
	assign pos_chan     = cfg_q[sacc_pkg::CTL_CH_MSB:0]; // R18
	assign neg_chan     = cfg_q[sacc_pkg::CTL_CH_MSB:0] ^ 3'h1; // R18
	assign polarity_sel = cfg_q[sacc_pkg::CTL_UNI]; // R17
	assign pwr_mode     = cfg_q[sacc_pkg::CTL_PWR_HI:sacc_pkg::CTL_PWR_LO]; // R14
	assign ext_clk_mode = ext_clk_q;
	assign hold_cap     = track_q;
	assign dac_code     = cv.code;
	assign conv_busy    = cv.busy;
	assign int_n        = int_n_q;
	assign data_out     = data_out_q;
	assign data_oe      = ~cs_s_q & ~rd_s_q; // R22

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	AST_WRITE_TRACKS: assert property ( // R02
		wr_event && !second_write |=> hold_cap && state_q != sacc_pkg::SACC_IDLE)
		else $error("write did not start tracking");

	AST_SECOND_WRITE_HOLDS: assert property ( // R03
		second_write |=> !hold_cap ##0 state_q == sacc_pkg::SACC_CONV ##0 cv.busy)
		else $error("second write did not start conversion");

	AST_FOURTH_EDGE: assert property ( // R04
		state_q == sacc_pkg::SACC_ACQ_INT && ext_clk_q |-> edge_cnt_q <= sacc_pkg::ACQ_EDGE_LAST)
		else $error("internal acquisition passed the fourth clock edge");

	AST_ONE_US: assert property ( // R05
		state_q == sacc_pkg::SACC_ACQ_INT && !ext_clk_q && !wr_event
		&& acq_cnt_q == sacc_pkg::ACQ_CNT_LAST |=> state_q == sacc_pkg::SACC_CONV && !hold_cap)
		else $error("internal acquisition not 125 cycles");

	AST_ABORT: assert property ( // R07
		wr_event && state_q == sacc_pkg::SACC_CONV |=> !cv.busy && hold_cap)
		else $error("write did not abort conversion");

	AST_SECOND_KEEPS_MUX: assert property ( // R11
		second_write |=> $stable(cfg_q[4:0]) && !cfg_q[5])
		else $error("second write changed channel setup");

	AST_INT_LOW: assert property ( // R12
		cv.done |=> !int_n ##0 result_q == $past(cv.result))
		else $error("interrupt not asserted on completion");

	AST_INT_CLEAR: assert property ( // R13
		(rd_event || wr_event) && !cv.done |=> int_n)
		else $error("interrupt not released by access");

	AST_CLK_MODE_KEPT: assert property ( // R23
		wr_event && !dat_s_q[7] |=> $stable(ext_clk_q))
		else $error("power-down code changed clock mode");

	AST_BUS_FLOAT: assert property ( // R22
		cs_s_q |-> !data_oe && !wr_event && !rd_event)
		else $error("deselected part drove the bus");

	AST_RESULT_HELD: assert property ( // R24
		!cv.done |=> $stable(result_q))
		else $error("result changed without completion");

endmodule // sacc_ctrl

//--- dv/sacc_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host model: byte-wide bus master and conversion clock source
// ****************************************************************
module sacc_host_model (
	input  wire logic       clock,
	output logic            cs_n,
	output logic            wr_n,
	output logic            rd_n,
	output logic            high_byte_sel,
	output logic            conv_clk_pin,
	output logic      [7:0] data_in,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe
);
	logic       clk_run;
	logic       hold_sel;
	logic [1:0] div_q;

	// Idle bus levels at time zero
	initial begin
		cs_n          = 1'b1;
		wr_n          = 1'b1;
		rd_n          = 1'b1;
		high_byte_sel = 1'b0;
		conv_clk_pin  = 1'b0;
		data_in       = 8'h5a;
		clk_run       = 1'b0;
		hold_sel      = 1'b0;
		div_q         = 2'h0;
	end

	// Pin clock of 8 system clocks; stands still outside frames
	always @(negedge clock) begin
		if (clk_run) begin
			div_q        <= div_q + 2'h1;
			conv_clk_pin <= (div_q == 2'h3) ? ~conv_clk_pin : conv_clk_pin;
		end
	end

	// Byte write; levels held 4 clocks so the sync flops see each one
	task automatic wr_byte(input logic [7:0] b, input logic sel);
		@(negedge clock);
		cs_n    = ~sel;
		data_in = b;
		repeat (4) @(negedge clock);
		wr_n = 1'b0;
		repeat (4) @(negedge clock);
		wr_n = 1'b1;
		repeat (4) @(negedge clock);
		cs_n    = ~hold_sel;
		data_in = ~b; // Released bus shows no stale byte
	endtask

	// Byte read; data taken while strobe is still low
	task automatic rd_byte(input logic hi, input logic sel, output logic [7:0] d,
		output logic oe);
		@(negedge clock);
		cs_n          = ~sel;
		high_byte_sel = hi;
		repeat (4) @(negedge clock);
		rd_n = 1'b0;
		repeat (5) @(negedge clock);
		d    = data_out;
		oe   = data_oe;
		rd_n = 1'b1;
		repeat (4) @(negedge clock);
		cs_n = 1'b1;
	endtask
endmodule // sacc_host_model

//--- dv/test_sacc_ctrl.sv
`timescale 1ns/1ps
module test_sacc_ctrl;
	logic        clock, sys_rst, comp_hi, cs_n, wr_n, rd_n, high_byte_sel, conv_clk_pin;
	logic [7:0]  data_in, data_out;
	logic        data_oe, int_n, hold_cap, neg_is_com, polarity_sel, ext_clk_mode, conv_busy;
	logic [2:0]  pos_chan, neg_chan;
	logic [9:0]  dac_code, target;
	logic [1:0]  pwr_mode;
	int          miscompares, compares;
	localparam int CONV_LEN = sacc_pkg::CONV_CYCLES * sacc_pkg::INT_TICK_CYC;

	sacc_ctrl sacc_ctrl_inst (.clock(clock), .sys_rst(sys_rst), .cs_n(cs_n), .wr_n(wr_n),
		.rd_n(rd_n), .high_byte_sel(high_byte_sel), .conv_clk_pin(conv_clk_pin),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .int_n(int_n),
		.comp_hi(comp_hi), .hold_cap(hold_cap), .pos_chan(pos_chan), .neg_chan(neg_chan),
		.neg_is_com(neg_is_com), .polarity_sel(polarity_sel), .dac_code(dac_code),
		.pwr_mode(pwr_mode), .ext_clk_mode(ext_clk_mode), .conv_busy(conv_busy));
	sacc_host_model sacc_host_model_inst (.clock(clock), .cs_n(cs_n), .wr_n(wr_n),
		.rd_n(rd_n), .high_byte_sel(high_byte_sel), .conv_clk_pin(conv_clk_pin),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe));

	// ****************************************************************
	// Clock, comparator model, watchdog
	// ****************************************************************
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Ideal comparator: input at or above trial code keeps the bit
	always @(negedge clock) comp_hi <= (target >= dac_code);
	// Whole run needs well under 20000 clocks
	initial begin
		repeat (60000) @(posedge clock);
		miscompares++;
		final_report();
	end

	// ****************************************************************
	// Shared checks and waits
	// ****************************************************************
	function automatic logic [7:0] exp_byte(input logic [9:0] r, input logic hi, input logic u);
		return hi ? {(u ? 6'h00 : {6{r[9]}}), r[9:8]} : r[7:0];
	endfunction
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		if (miscompares == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Bounded waits; a timeout shows up in the later length checks
	task automatic wait_hold(output int n);
		n = 0;
		while (hold_cap !== 1'b0 && n < 1000) begin
			@(negedge clock);
			n++;
		end
	endtask
	task automatic wait_int(output int n);
		n = 0;
		while (int_n !== 1'b0 && n < 1000) begin
			@(negedge clock);
			n++;
		end
	endtask
	task automatic wr(input logic [7:0] b, input logic sel);
		sacc_host_model_inst.wr_byte(b, sel);
		@(negedge clock);
	endtask
	// Both result bytes, plus interrupt release by the read
	task automatic read_both(input logic uni);
		logic [7:0] d;
		logic       oe;
		sacc_host_model_inst.rd_byte(1'b0, 1'b1, d, oe);
		check("low_byte", d, exp_byte(target, 1'b0, uni));
		check("data_oe", oe, 1'b1);
		check("int_n_read", int_n, 1'b1);
		sacc_host_model_inst.rd_byte(1'b1, 1'b1, d, oe);
		check("high_byte", d, exp_byte(target, 1'b1, uni));
	endtask
	// Internally timed acquisition with internal clock, then full readout
	task automatic run_int(input logic [7:0] b);
		int n;
		wr(b, 1'b1);
		check("hold_cap", hold_cap, 1'b1);
		check("pos_chan", pos_chan, b[2:0]);
		check("neg_is_com", neg_is_com, b[4]);
		if (!b[4]) check("neg_chan", neg_chan, b[2:0] ^ 3'h1);
		check("polarity", polarity_sel, b[3]);
		check("pwr_mode", pwr_mode, b[7:6]);
		check("ext_clk", ext_clk_mode, 1'b0);
		wait_hold(n);
		check("acq_len", n >= 110 && n <= 125, 1'b1);
		check("busy", conv_busy, 1'b1);
		wait_int(n);
		check("conv_len", n >= CONV_LEN && n <= CONV_LEN + 4, 1'b1);
		read_both(b[3]);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [7:0] b, d;
		logic       oe;
		int         n, k;
		logic [7:0] corner [2] = '{8'h9f, 8'h80};
		sys_rst     = 1'b1;
		target      = 10'h000;
		miscompares = 0;
		compares    = 0;
		void'($urandom(13486));
		repeat (8) @(negedge clock);
		sys_rst = 1'b0;
		check("rst_int_n", int_n, 1'b1);
		check("rst_oe", data_oe, 1'b0);
		check("rst_ext_clk", ext_clk_mode, 1'b1);
		// Corner bytes first, then random configurations and inputs
		for (k = 0; k < 6; k++) begin
			b      = (k < 2) ? corner[k] : {3'b100, 5'($urandom)};
			target = (k == 0) ? 10'h3ff : (k == 1) ? 10'h200 : 10'($urandom);
			run_int(b);
		end
		// New write mid-conversion restarts acquisition
		wr(8'h9a, 1'b1);
		wait_hold(n);
		repeat (20) @(negedge clock);
		target = 10'h155;
		wr(8'h83, 1'b1);
		check("abort_busy", conv_busy, 1'b0);
		check("abort_hold", hold_cap, 1'b1);
		wait_hold(n);
		wait_int(n);
		check("abort_int", int_n, 1'b0);
		// Deselected strobes change nothing
		wr(8'h9e, 1'b0);
		check("desel_chan", pos_chan, 3'h3);
		sacc_host_model_inst.rd_byte(1'b0, 1'b0, d, oe);
		check("desel_oe", oe, 1'b0);
		check("desel_int", int_n, 1'b0);
		// Host-timed acquisition: open write, then bit5 clear with new power bits
		target = 10'h2c9;
		wr(8'hb5, 1'b1);
		check("wr_int_n", int_n, 1'b1);
		repeat (300) @(negedge clock);
		check("ext_acq_hold", hold_cap, 1'b1);
		check("ext_acq_busy", conv_busy, 1'b0);
		wr(8'h15, 1'b1);
		check("ext_hold", hold_cap, 1'b0);
		check("ext_busy", conv_busy, 1'b1);
		check("ext_pwr", pwr_mode, 2'h0);
		check("ext_clkmode", ext_clk_mode, 1'b0);
		check("ext_chan", pos_chan, 3'h5);
		wait_int(n);
		// Counted from the write's return, two clocks after the run began
		check("ext_conv_len", n >= CONV_LEN - 3 && n <= CONV_LEN + 1, 1'b1);
		read_both(1'b0);
		// Pin clock mode: hold on fourth falling pin edge
		target                        = 10'h0f3;
		sacc_host_model_inst.hold_sel = 1'b1;
		wr(8'hd8, 1'b1);
		check("pin_clk_mode", ext_clk_mode, 1'b1);
		sacc_host_model_inst.clk_run = 1'b1;
		k                            = 0;
		b[0]                         = conv_clk_pin;
		for (n = 0; n < 100 && hold_cap !== 1'b0; n++) begin
			@(negedge clock);
			k    = (b[0] && !conv_clk_pin) ? k + 1 : k;
			b[0] = conv_clk_pin;
		end
		check("pin_edges", k, 4);
		wait_int(n);
		check("pin_conv_len", n >= 96 && n <= 112, 1'b1);
		sacc_host_model_inst.clk_run  = 1'b0;
		sacc_host_model_inst.hold_sel = 1'b0;
		read_both(1'b1);
		final_report();
	end
endmodule // test_sacc_ctrl
